// >>> src/adcg_config_ctrl.v
// Gain, global-chop and current-detect configuration with the detection engine and its register port.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "adcg_map.vh"

// Contract
// - Channel 5 gain field bits 6:4 selects gain two to the code, 1 to 128.
// - Channel 4 gain field bits 2:0 selects gain the same way, reset zero.
// - Chop enabled waits two to the code plus one modulator periods before measuring.
// - Bit 7 selects detection by any channel or by all channels.
// - Bits 6:4 set the exceedance count needed, two to the code.
// - Detect enable bit 0; bits 3:1 pick the window length in conversions.
// - Upper threshold word holds threshold bits 23:8, two's complement.
// - Lower word bits 15:8 hold the threshold's least significant byte.
// - Lower word bits 7:4 ignore writes and read as zero.
// - Lower word bits 3:0 hold the offset filter setting, reset zero.
module adcg_config_ctrl #(
   parameter CHANNELS = 6,
   parameter ADDR_WIDTH = 8
) (
   // Clock and reset
   input wire ref_clk,
   input wire reset,
   // Register port
   input wire [ADDR_WIDTH-1:0] regAddr,
   input wire [15:0] regWrData,
   input wire regWrite,
   input wire regRead,
   output reg [15:0] regRdData,
   // Converter side
   input wire modClkEn,
   input wire chopSwitch,
   input wire sampleValid,
   input wire [CHANNELS*24-1:0] sampleData,
   // Configuration outputs
   output wire [2:0] ampGainCh4,
   output wire [2:0] ampGainCh5,
   output reg [7:0] gainFactorCh4,
   output reg [7:0] gainFactorCh5,
   output wire chopEnable,
   output wire measureEnable,
   output wire [3:0] offsetFilterSetting,
   output wire detectModeEnable,
   // Detection results and interrupt
   output reg detectEvent,
   output reg [CHANNELS-1:0] channelExceeded,
   output wire irq
);
   localparam ST_IDLE = 3'b001;
   localparam ST_RUN = 3'b010;
   localparam ST_EVAL = 3'b100;

   reg [15:0] gainSelect;
   reg [15:0] chopDetectCfg;
   reg [15:0] thresholdUpper;
   reg [15:0] thresholdLower;
   reg [2:0] status;
   reg [2:0] intMask;
   reg [2:0] state;
   reg [11:0] windowCnt;
   reg windowDone;
   reg [2:0] next_status;
   reg [15:0] next_rdData;
   reg [11:0] windowLen;

   wire [3:0] chopDelayCode;
   wire detectAllChannels;
   wire [2:0] detectExceedCount;
   wire [2:0] detectWindowLength;
   wire signed [23:0] detectThreshold;
   wire [7:0] exceedNeeded;
   wire [16:0] settleCount;
   wire chopStart;
   wire cfgChopOn;
   wire phaseRestart;
   wire [3:0] startDelayCode;
   wire settleBusy;
   wire settleDone;
   wire statRead;
   wire [CHANNELS-1:0] exceedHit;
   wire [CHANNELS-1:0] channelHit;
   wire countEnable;

   assign ampGainCh5 = gainSelect[`ADCG_GAIN5_LSB +: 3];
   assign ampGainCh4 = gainSelect[`ADCG_GAIN4_LSB +: 3];
   assign chopDelayCode = chopDetectCfg[`ADCG_CHOP_DLY_LSB +: 4];
   assign chopEnable = chopDetectCfg[`ADCG_CHOP_EN_BIT];
   assign detectAllChannels = chopDetectCfg[`ADCG_ALLCH_BIT];
   assign detectExceedCount = chopDetectCfg[`ADCG_NUM_LSB +: 3];
   assign detectWindowLength = chopDetectCfg[`ADCG_LEN_LSB +: 3];
   assign detectModeEnable = chopDetectCfg[`ADCG_DETEN_BIT];
   assign detectThreshold = {thresholdUpper, thresholdLower[`ADCG_THL_LOW_LSB +: 8]};
   assign offsetFilterSetting = thresholdLower[`ADCG_FILT_LSB +: 4];
   assign exceedNeeded = 8'h01 << detectExceedCount;

   // Gain codes are turned into their binary amplification factor.
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         gainFactorCh4 <= 8'h01;
         gainFactorCh5 <= 8'h01;
      end else begin
         gainFactorCh5 <= 8'h01 << ampGainCh5;
         gainFactorCh4 <= 8'h01 << ampGainCh4;
      end
   end

   // Register writes; reserved lower-word bits are never stored.
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         gainSelect <= `ADCG_RST_GAIN;
         chopDetectCfg <= `ADCG_RST_CFG;
         thresholdUpper <= `ADCG_RST_THU;
         thresholdLower <= `ADCG_RST_THL;
         intMask <= `ADCG_RST_MASK;
      end else if (regWrite) begin
         case (regAddr)
            `ADCG_OFS_GAIN: begin
               gainSelect <= regWrData;
            end
            `ADCG_OFS_CFG: begin
               chopDetectCfg <= regWrData;
            end
            `ADCG_OFS_THU: begin
               thresholdUpper <= regWrData;
            end
            `ADCG_OFS_THL: begin
               thresholdLower <= regWrData & `ADCG_THL_WMASK;
            end
            `ADCG_OFS_MASK: begin
               intMask <= regWrData[2:0];
            end
            default: begin
               gainSelect <= gainSelect;
            end
         endcase
      end
   end

   // Settling restarts on each chop phase change and when chop is switched on.
   // A write that switches chop on loads the delay code of the word being written.
   assign cfgChopOn = regWrite && (regAddr == `ADCG_OFS_CFG) && regWrData[`ADCG_CHOP_EN_BIT] &&
      !chopEnable;
   assign phaseRestart = chopEnable && chopSwitch;
   assign chopStart = phaseRestart || cfgChopOn;
   assign startDelayCode = cfgChopOn ? regWrData[`ADCG_CHOP_DLY_LSB +: 4] : chopDelayCode;
   assign settleCount = 17'h00002 << startDelayCode;
   assign measureEnable = !chopEnable || !settleBusy;

   adcg_settle_timer #(
      .WIDTH(17)
   ) settleTimer (
      .ref_clk(ref_clk),
      .reset(reset),
      .start(chopStart),
      .tick(modClkEn),
      .count(settleCount),
      .busy(settleBusy),
      .done(settleDone)
   );

   // Window length lookup.
   always @* begin
      case (detectWindowLength)
         3'd0: windowLen = `ADCG_LEN_0;
         3'd1: windowLen = `ADCG_LEN_1;
         3'd2: windowLen = `ADCG_LEN_2;
         3'd3: windowLen = `ADCG_LEN_3;
         3'd4: windowLen = `ADCG_LEN_4;
         3'd5: windowLen = `ADCG_LEN_5;
         3'd6: windowLen = `ADCG_LEN_6;
         default: windowLen = `ADCG_LEN_7;
      endcase
   end

   assign countEnable = (state == ST_RUN) && sampleValid && measureEnable;

   // Per channel exceedance test and counter.
   // Counters saturate so that a long window cannot wrap them below the needed count.
   genvar g;
   generate
      for (g = 0; g < CHANNELS; g = g + 1) begin : chan
         wire signed [23:0] sample;
         wire [24:0] magnitude;
         wire signed [25:0] magSigned;
         wire signed [25:0] thrSigned;
         reg [7:0] exceedCnt;
         assign sample = sampleData[g*24 +: 24];
         assign magnitude = sample[23] ? (25'd0 - {sample[23], sample}) : {1'b0, sample};
         assign magSigned = {1'b0, magnitude};
         assign thrSigned = {{2{detectThreshold[23]}}, detectThreshold};
         assign exceedHit[g] = magSigned > thrSigned;
         assign channelHit[g] = exceedCnt >= exceedNeeded;
         always @(posedge ref_clk or posedge reset) begin
            if (reset) begin
               exceedCnt <= 8'h00;
            end else if (state != ST_RUN) begin
               exceedCnt <= 8'h00;
            end else if (countEnable && exceedHit[g] && exceedCnt != `ADCG_CNT_MAX) begin
               exceedCnt <= exceedCnt + 8'h01;
            end
         end
      end
   endgenerate

   // Measurement window sequencing.
   // A sample that arrives in the evaluation cycle is not counted.
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         state <= ST_IDLE;
         windowCnt <= 12'd0;
         windowDone <= 1'b0;
         detectEvent <= 1'b0;
         channelExceeded <= {CHANNELS{1'b0}};
      end else begin
         windowDone <= 1'b0;
         detectEvent <= 1'b0;
         case (state)
            ST_IDLE: begin
               windowCnt <= 12'd0;
               if (detectModeEnable) begin
                  state <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (!detectModeEnable) begin
                  state <= ST_IDLE;
               end else if (countEnable) begin
                  if (windowCnt == windowLen - 12'd1) begin
                     state <= ST_EVAL;
                  end else begin
                     windowCnt <= windowCnt + 12'd1;
                  end
               end
            end
            ST_EVAL: begin
               windowCnt <= 12'd0;
               windowDone <= 1'b1;
               channelExceeded <= channelHit;
               detectEvent <= detectAllChannels ? &channelHit : |channelHit;
               state <= detectModeEnable ? ST_RUN : ST_IDLE;
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Sticky event flags; a read of the status word clears it, new events win.
   assign statRead = regRead && regAddr == `ADCG_OFS_STAT;

   always @* begin
      next_status = statRead ? 3'h0 : status;
      if (detectEvent) begin
         next_status[`ADCG_ST_DET] = 1'b1;
      end
      if (windowDone) begin
         next_status[`ADCG_ST_WIN] = 1'b1;
      end
      if (settleDone) begin
         next_status[`ADCG_ST_SET] = 1'b1;
      end
   end

   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         status <= `ADCG_RST_STAT;
      end else begin
         status <= next_status;
      end
   end

   assign irq = |(status & intMask);

   // Read data appear the cycle after the read strobe.
   // Reserved lower threshold bits are masked on write, so they read back as zero.
   always @* begin
      case (regAddr)
         `ADCG_OFS_GAIN: next_rdData = gainSelect;
         `ADCG_OFS_CFG: next_rdData = chopDetectCfg;
         `ADCG_OFS_THU: next_rdData = thresholdUpper;
         `ADCG_OFS_THL: next_rdData = thresholdLower;
         `ADCG_OFS_STAT: next_rdData = {13'h0000, status};
         `ADCG_OFS_MASK: next_rdData = {13'h0000, intMask};
         default: next_rdData = 16'h0000;
      endcase
   end

   // Outside the answer cycle of a read the data lines rest at zero.
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         regRdData <= 16'h0000;
      end else if (regRead) begin
         regRdData <= next_rdData;
      end else begin
         regRdData <= 16'h0000;
      end
   end
endmodule
`default_nettype wire

// >>> src/adcg_map.vh
// Register offsets, field positions, reset values and lookup figures of the converter control block.
`ifndef ADCG_MAP_VH
`define ADCG_MAP_VH

`define ADCG_OFS_GAIN 8'h05
`define ADCG_OFS_CFG 8'h06
`define ADCG_OFS_THU 8'h07
`define ADCG_OFS_THL 8'h08
`define ADCG_OFS_STAT 8'h10
`define ADCG_OFS_MASK 8'h11

`define ADCG_RST_GAIN 16'h0000
`define ADCG_RST_CFG 16'h0600
`define ADCG_RST_THU 16'h0000
`define ADCG_RST_THL 16'h0000
`define ADCG_RST_STAT 3'h0
`define ADCG_RST_MASK 3'h0

`define ADCG_GAIN5_LSB 4
`define ADCG_GAIN4_LSB 0
`define ADCG_CHOP_DLY_LSB 9
`define ADCG_CHOP_EN_BIT 8
`define ADCG_ALLCH_BIT 7
`define ADCG_NUM_LSB 4
`define ADCG_LEN_LSB 1
`define ADCG_DETEN_BIT 0
`define ADCG_THL_LOW_LSB 8
`define ADCG_FILT_LSB 0
`define ADCG_THL_WMASK 16'hFF0F

`define ADCG_ST_DET 0
`define ADCG_ST_WIN 1
`define ADCG_ST_SET 2

`define ADCG_LEN_0 12'd128
`define ADCG_LEN_1 12'd256
`define ADCG_LEN_2 12'd512
`define ADCG_LEN_3 12'd768
`define ADCG_LEN_4 12'd1280
`define ADCG_LEN_5 12'd1792
`define ADCG_LEN_6 12'd2560
`define ADCG_LEN_7 12'd3584

`define ADCG_CNT_MAX 8'hFF

`endif

// >>> src/adcg_settle_timer.v
// Down counter that measures the chop settling delay in modulator clock ticks.
`timescale 1ns/10ps
`default_nettype none
module adcg_settle_timer #(
   parameter WIDTH = 17
) (
   // Clock and reset
   input wire ref_clk,
   input wire reset,
   // Control
   input wire start,
   input wire tick,
   input wire [WIDTH-1:0] count,
   // Status
   output reg busy,
   output reg done
);
   reg [WIDTH-1:0] remain;

   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         remain <= {WIDTH{1'b0}};
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            remain <= count;
            busy <= 1'b1;
         end else if (busy && tick) begin
            if (remain == {{(WIDTH-1){1'b0}}, 1'b1}) begin
               busy <= 1'b0;
               done <= 1'b1;
            end else begin
               remain <= remain - {{(WIDTH-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule
`default_nettype wire

// >>> tb/adcg_config_ctrl_monitor.sv
// Concurrent checks on the ports of the converter control block.
`timescale 1ns/10ps
`default_nettype none
module adcg_config_ctrl_monitor #(
   parameter CHANNELS = 6,
   parameter ADDR_WIDTH = 8
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Register port
   input wire logic [ADDR_WIDTH-1:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [15:0] regRdData,
   // Converter side and outputs
   input wire logic chopSwitch,
   input wire logic [2:0] ampGainCh4,
   input wire logic [2:0] ampGainCh5,
   input wire logic [7:0] gainFactorCh4,
   input wire logic [7:0] gainFactorCh5,
   input wire logic chopEnable,
   input wire logic measureEnable,
   input wire logic [3:0] offsetFilterSetting,
   input wire logic detectModeEnable,
   input wire logic detectEvent
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   sequence chop_start;
      chopSwitch && chopEnable;
   endsequence
   sequence cfg_write;
      regWrite && regAddr == 8'h06;
   endsequence
   sequence chop_turn_on;
      regWrite && regAddr == 8'h06 && regWrData[8] && !chopEnable;
   endsequence
   a_thl_reserved: assert property (regRead && regAddr == 8'h08 |=> regRdData[7:4] == 4'h0)
      else $error("reserved threshold bits not zero");
   a_gain4_factor: assert property ($stable(ampGainCh4) |-> gainFactorCh4 == (8'h01 << ampGainCh4))
      else $error("channel 4 gain factor wrong");
   a_gain5_factor: assert property ($stable(ampGainCh5) |-> gainFactorCh5 == (8'h01 << ampGainCh5))
      else $error("channel 5 gain factor wrong");
   a_gain_write: assert property (regWrite && regAddr == 8'h05 |=> ampGainCh4 == $past(regWrData[2:0])
      && ampGainCh5 == $past(regWrData[6:4])) else $error("gain codes not stored");
   a_chop_restart: assert property (chop_start |=> !measureEnable)
      else $error("chop switch did not stop measuring");
   a_chop_off: assert property (!chopEnable |-> measureEnable)
      else $error("measuring held without chop");
   a_chop_enable: assert property (chop_turn_on |=> !measureEnable)
      else $error("chop switch-on did not stop measuring");
   a_cfg_fields: assert property (cfg_write |=> detectModeEnable == $past(regWrData[0])
      && chopEnable == $past(regWrData[8])) else $error("config bits not stored");
   a_filter_write: assert property (regWrite && regAddr == 8'h08 |=>
      offsetFilterSetting == $past(regWrData[3:0])) else $error("filter setting not stored");
   a_event_pulse: assert property (detectEvent |=> !detectEvent)
      else $error("detect event longer than one cycle");
   a_event_enabled: assert property (detectEvent |-> $past(detectModeEnable, 2))
      else $error("detect event while mode off");
endmodule
bind adcg_config_ctrl adcg_config_ctrl_monitor #(.CHANNELS(CHANNELS), .ADDR_WIDTH(ADDR_WIDTH))
   adcg_config_ctrl_monitor_i (
   .ref_clk(ref_clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
   .regRead(regRead), .regRdData(regRdData), .chopSwitch(chopSwitch), .ampGainCh4(ampGainCh4),
   .ampGainCh5(ampGainCh5), .gainFactorCh4(gainFactorCh4), .gainFactorCh5(gainFactorCh5),
   .chopEnable(chopEnable), .measureEnable(measureEnable), .offsetFilterSetting(offsetFilterSetting),
   .detectModeEnable(detectModeEnable), .detectEvent(detectEvent));
`default_nettype wire

// >>> tb/adcg_config_ctrl_bench.sv
// Self-checking bench for the converter control block.
`timescale 1ns/10ps
`default_nettype none
module adcg_config_ctrl_bench;
   logic ref_clk = 0, reset = 1, regWrite = 0, regRead = 0, modClkEn = 0, chopSwitch = 0, sampleValid = 0;
   logic [7:0] regAddr = 8'h00;
   logic [15:0] regWrData = 16'h0000, q;
   logic [143:0] sampleData = 144'h0, sd;
   logic [39:0] rows [0:7];
   logic seen;
   wire [15:0] regRdData;
   wire [2:0] ampGainCh4, ampGainCh5;
   wire [7:0] gainFactorCh4, gainFactorCh5;
   wire [3:0] offsetFilterSetting;
   wire [5:0] channelExceeded;
   wire chopEnable, measureEnable, detectModeEnable, detectEvent, irq;
   integer bad_count = 0, n_compared = 0, i, k, c;
   always #2.5 ref_clk = ~ref_clk;
   adcg_config_ctrl adcg_config_ctrl_i (.ref_clk(ref_clk), .reset(reset), .regAddr(regAddr),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .modClkEn(modClkEn), .chopSwitch(chopSwitch), .sampleValid(sampleValid), .sampleData(sampleData),
      .ampGainCh4(ampGainCh4), .ampGainCh5(ampGainCh5), .gainFactorCh4(gainFactorCh4),
      .gainFactorCh5(gainFactorCh5), .chopEnable(chopEnable), .measureEnable(measureEnable),
      .offsetFilterSetting(offsetFilterSetting), .detectModeEnable(detectModeEnable),
      .detectEvent(detectEvent), .channelExceeded(channelExceeded), .irq(irq));
   task chk(input logic [15:0] s, input logic [15:0] e);
      n_compared = n_compared + 1;
      if (s !== e) begin
         bad_count = bad_count + 1;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task wrap_up;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task step(input integer n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1;
      @(posedge ref_clk);
      regWrite <= 0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge ref_clk);
      regAddr <= a;
      regRead <= 1;
      @(posedge ref_clk);
      regRead <= 0;
      #1 q = regRdData;
   endtask
   task pulse_tick;
      @(posedge ref_clk);
      modClkEn <= 1;
      @(posedge ref_clk);
      modClkEn <= 0;
   endtask
   task chop_pulse;
      @(posedge ref_clk);
      chopSwitch <= 1;
      @(posedge ref_clk);
      chopSwitch <= 0;
   endtask
   task window(input logic [5:0] hot);
      for (i = 0; i < 128; i = i + 1) begin
         sd = {6{24'h000010}};
         for (c = 0; c < 6; c = c + 1) begin
            if (hot[c] && i < 2) sd[c*24+:24] = 24'hFFFFEF;
         end
         @(posedge ref_clk);
         sampleValid <= 1;
         sampleData <= sd;
         @(posedge ref_clk);
         sampleValid <= 0;
      end
      seen = 0;
      for (i = 0; i < 8; i = i + 1) begin
         step(1);
         if (detectEvent === 1'b1) seen = 1;
      end
   endtask
   initial begin
      #100000;
      bad_count = bad_count + 1;
      wrap_up;
   end
   initial begin
      // Reserved upper config bits are always written as zero.
      rows[0] = {8'h05, 16'h0077, 16'h0077};
      rows[1] = {8'h06, 16'h1FFE, 16'h1FFE};
      rows[2] = {8'h06, 16'h0600, 16'h0600};
      rows[3] = {8'h07, 16'h8001, 16'h8001};
      rows[4] = {8'h08, 16'hFFFF, 16'hFF0F};
      rows[5] = {8'h08, 16'h00A5, 16'h0005};
      rows[6] = {8'h09, 16'h1234, 16'h0000};
      rows[7] = {8'h11, 16'h0007, 16'h0007};
      repeat (6) @(posedge ref_clk);
      reset <= 0;
      step(1);
      chk(16'(gainFactorCh4), 16'h0001);
      chk(16'(measureEnable), 16'h0001);
      for (k = 5; k < 9; k = k + 1) begin
         rd(k[7:0]);
         chk(q, (k == 6) ? 16'h0600 : 16'h0000);
      end
      $display("test reset done");
      for (k = 0; k < 8; k = k + 1) begin
         wr(rows[k][39:32], rows[k][31:16]);
         rd(rows[k][39:32]);
         chk(q, rows[k][15:0]);
      end
      $display("test registers done");
      for (k = 0; k < 8; k = k + 1) begin
         wr(8'h05, {9'h000, k[2:0], 1'b0, 3'(7 - k)});
         step(1);
         chk(16'(gainFactorCh4), 16'h0001 << (7 - k));
         chk(16'(gainFactorCh5), 16'h0001 << k);
      end
      $display("test gains done");
      wr(8'h11, 16'h0000);
      wr(8'h06, 16'h0100);
      step(1);
      chk(16'(measureEnable), 16'h0000);
      pulse_tick;
      step(1);
      chk(16'(measureEnable), 16'h0000);
      pulse_tick;
      step(1);
      chk(16'(measureEnable), 16'h0001);
      chop_pulse;
      pulse_tick;
      step(1);
      chk(16'(measureEnable), 16'h0000);
      pulse_tick;
      step(3);
      chk(16'(measureEnable), 16'h0001);
      chk(16'(irq), 16'h0000);
      wr(8'h11, 16'h0004);
      step(1);
      chk(16'(irq), 16'h0001);
      rd(8'h10);
      chk(q, 16'h0004);
      step(1);
      chk(16'(irq), 16'h0000);
      $display("test chop done");
      wr(8'h07, 16'h0000);
      wr(8'h08, 16'h1000);
      wr(8'h06, 16'h0011);
      window(6'h04);
      chk(16'(seen), 16'h0001);
      chk(16'(channelExceeded), 16'h0004);
      rd(8'h10);
      chk(q, 16'h0003);
      wr(8'h06, 16'h0000);
      wr(8'h06, 16'h0091);
      window(6'h04);
      chk(16'(seen), 16'h0000);
      chk(16'(channelExceeded), 16'h0004);
      window(6'h3F);
      chk(16'(seen), 16'h0001);
      chk(16'(channelExceeded), 16'h003F);
      $display("test detect done");
      @(posedge ref_clk);
      reset <= 1;
      repeat (2) @(posedge ref_clk);
      reset <= 0;
      step(1);
      chk(16'(gainFactorCh5), 16'h0001);
      chk(16'(channelExceeded), 16'h0000);
      rd(8'h06);
      chk(q, 16'h0600);
      $display("test reset again done");
      wrap_up;
   end
endmodule
`default_nettype wire
